// File: ucs_ctrl_status.sv
// Serial control/status register with receive FIFO and transmit holding register.
// Assumes the serializer and deserializer sit outside and talk over plain handshakes.
`timescale 1ns/10ps
`default_nettype none
module ucs_ctrl_status
   import ucs_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RSTN,
   // SFR port
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic SFR_BIT_WR,
   input wire logic [2:0] SFR_BIT_SEL,
   input wire logic [7:0] SFR_WDATA,
   input wire logic BUF_WR,
   input wire logic BUF_RD,
   output logic [7:0] SFR_RDATA,
   output logic [7:0] BUF_RDATA,
   // Options from the mode register
   input wire logic PARITY_EN,
   input wire logic EXTRA_EN,
   // Receiver side
   input wire ucs_pkg::ucs_rxchar_s RX_CHAR,
   output logic RX_ENABLE,
   // Transmitter side
   output logic TX_VALID,
   output logic [7:0] TX_DATA,
   output logic TX_EXTRA,
   input wire logic TX_TAKE,
   input wire logic TX_STOP_START,
   output logic TX_STUCK_LOW
);
   import ucs_pkg::*;

   ucs_state_s st_ff;
   ucs_state_s nxt_st;
   logic reg_hit;
   logic [7:0] wval;
   logic rx_in;
   logic pop;

   // ==========================================================
   // Next-state logic
   // Reads are combinational from the flops, so SFR_RD carries no meaning here
   always_comb
   begin
      reg_hit = (SFR_ADDR == UCS_ADDR_SCSR);
      wval = st_ff.scsr;
      if (SFR_BIT_WR && reg_hit)
      begin
         wval[SFR_BIT_SEL] = SFR_WDATA[0];
      end
      else if (SFR_WR && reg_hit)
      begin
         wval = SFR_WDATA;
      end
      rx_in = RX_CHAR.valid && st_ff.scsr[UCS_BIT_REN] && RX_CHAR.stop_ok;
      pop = BUF_RD && (st_ff.cnt != 2'd0);
      nxt_st = st_ff;
      // Software write first, then hardware sets win, so an event
      // landing on the cycle of a clearing write is never lost
      nxt_st.scsr = wval;
      nxt_st.scsr[UCS_BIT_THE] = st_ff.scsr[UCS_BIT_THE];
      // ======================================================
      // Receive FIFO
      // Pop before push, so a read and an arrival in one cycle keep
      // both bytes and raise no false overrun
      if (pop)
      begin
         nxt_st.fifo0 = st_ff.fifo1;
         nxt_st.fifo1 = st_ff.fifo2;
         nxt_st.cnt = st_ff.cnt - 2'd1;
      end
      if (rx_in)
      begin
         if (nxt_st.cnt == 2'(UCS_FIFO_DEPTH))
         begin
            nxt_st.scsr[UCS_BIT_OVR] = 1'b1;
         end
         else
         begin
            case (nxt_st.cnt)
               2'd0: nxt_st.fifo0 = {RX_CHAR.data, RX_CHAR.extra, RX_CHAR.parity_bad};
               2'd1: nxt_st.fifo1 = {RX_CHAR.data, RX_CHAR.extra, RX_CHAR.parity_bad};
               default: nxt_st.fifo2 = {RX_CHAR.data, RX_CHAR.extra, RX_CHAR.parity_bad};
            endcase
            nxt_st.cnt = nxt_st.cnt + 2'd1;
         end
      end
      // Ready flag cannot clear while data remains
      if (nxt_st.cnt != 2'd0)
      begin
         nxt_st.scsr[UCS_BIT_RRDY] = 1'b1;
      end
      if (nxt_st.cnt != 2'd0)
      begin
         nxt_st.scsr[UCS_BIT_RXX] = nxt_st.fifo0[1];
         // Re-raised each cycle a bad byte is oldest; a clear only
         // sticks once that byte has been read out
         if (PARITY_EN && nxt_st.fifo0[0])
         begin
            nxt_st.scsr[UCS_BIT_PERR] = 1'b1;
         end
      end
      // ======================================================
      // Transmit holding register
      // A write in the cycle of a take still counts as a write to a full register
      if (TX_TAKE && st_ff.holding_full)
      begin
         nxt_st.holding_full = 1'b0;
      end
      if (BUF_WR)
      begin
         if (st_ff.holding_full)
         begin
            // Wedges the transmitter; only RSTN clears it
            nxt_st.stuck = 1'b1;
         end
         else
         begin
            nxt_st.holding_full = 1'b1;
            nxt_st.holding_data = SFR_WDATA;
         end
      end
      nxt_st.scsr[UCS_BIT_THE] = !nxt_st.holding_full;
      if (TX_STOP_START)
      begin
         nxt_st.scsr[UCS_BIT_TDONE] = 1'b1;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         st_ff <= '0;
         st_ff.scsr <= UCS_SCSR_RESET;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Outputs
   // Data buffer shows the oldest entry; it stays readable with the receiver off
   assign SFR_RDATA = reg_hit ? st_ff.scsr : 8'h00;
   assign BUF_RDATA = st_ff.fifo0[9:2];
   assign RX_ENABLE = st_ff.scsr[UCS_BIT_REN];
   // A wedged transmitter offers nothing, so the line stays low
   assign TX_VALID = st_ff.holding_full && !st_ff.stuck;
   assign TX_DATA = st_ff.holding_data;
   // Parity owns the extra slot whenever it is on
   assign TX_EXTRA = EXTRA_EN && !PARITY_EN && st_ff.scsr[UCS_BIT_TXX];
   assign TX_STUCK_LOW = st_ff.stuck;

   // ==========================================================
   // Checks: transmit side
   the_set_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (TX_TAKE && st_ff.holding_full && !BUF_WR) |=> st_ff.scsr[UCS_BIT_THE])
      else $error("empty flag not set after take");
   the_clear_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (BUF_WR && !st_ff.holding_full) |=> (!st_ff.scsr[UCS_BIT_THE] && TX_DATA == $past(SFR_WDATA)))
      else $error("empty flag not cleared by write");
   tdone_set_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      TX_STOP_START |=> st_ff.scsr[UCS_BIT_TDONE]) else $error("tx done not set");
   stuck_set_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (BUF_WR && st_ff.holding_full) |=> (TX_STUCK_LOW && !TX_VALID))
      else $error("write to full holding register not trapped");
   stuck_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      TX_STUCK_LOW |=> (TX_STUCK_LOW && !TX_VALID)) else $error("stuck state left without reset");

   // ==========================================================
   // Checks: receive side
   ovr_set_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (rx_in && !pop && st_ff.cnt == 2'd3) |=> st_ff.scsr[UCS_BIT_OVR]) else $error("overrun not set");
   ovr_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (st_ff.scsr[UCS_BIT_OVR] && !(SFR_WR && reg_hit) && !SFR_BIT_WR) |=> st_ff.scsr[UCS_BIT_OVR])
      else $error("overrun lost");
   perr_set_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (PARITY_EN && rx_in && RX_CHAR.parity_bad && st_ff.cnt == 2'd0) |=> st_ff.scsr[UCS_BIT_PERR])
      else $error("parity flag not set");
   perr_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (st_ff.scsr[UCS_BIT_PERR] && !SFR_WR && !SFR_BIT_WR) |=> st_ff.scsr[UCS_BIT_PERR])
      else $error("parity flag cleared by hardware");
   fifo_cap_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (st_ff.cnt == 2'd3 && !BUF_RD) |=> st_ff.cnt == 2'd3) else $error("full fifo count moved");
   stop_drop_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (RX_CHAR.valid && !RX_CHAR.stop_ok && !pop) |=> st_ff.cnt == $past(st_ff.cnt))
      else $error("byte with bad stop bit stored");
   rx_store_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (rx_in && st_ff.cnt == 2'd0) |=> (st_ff.cnt == 2'd1 && BUF_RDATA == $past(RX_CHAR.data)))
      else $error("received byte not stored");
   pop_shift_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (pop && !rx_in && st_ff.cnt == 2'd2) |=> (st_ff.cnt == 2'd1 && BUF_RDATA == $past(st_ff.fifo1[9:2])))
      else $error("fifo read did not advance");
   rx_off_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (!st_ff.scsr[UCS_BIT_REN] && !pop) |=> st_ff.cnt == $past(st_ff.cnt)) else $error("rx while off");
   rrdy_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (st_ff.cnt != 2'd0) |-> st_ff.scsr[UCS_BIT_RRDY]) else $error("ready low with data");
endmodule : ucs_ctrl_status
`default_nettype wire

// File: ucs_pkg.sv
// Package for the serial control/status register block.
// Assumes a single core clock domain and an SFR-style register port.
`default_nettype none
package ucs_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] UCS_ADDR_SCSR = 8'h98;
   localparam logic [7:0] UCS_SCSR_RESET = 8'h20;
   // ==========================================================
   // Field positions
   localparam int UCS_BIT_OVR = 7;
   localparam int UCS_BIT_PERR = 6;
   localparam int UCS_BIT_THE = 5;
   localparam int UCS_BIT_REN = 4;
   localparam int UCS_BIT_TXX = 3;
   localparam int UCS_BIT_RXX = 2;
   localparam int UCS_BIT_TDONE = 1;
   localparam int UCS_BIT_RRDY = 0;
   localparam int UCS_FIFO_DEPTH = 3;
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic extra;
      logic parity_bad;
      logic stop_ok;
   } ucs_rxchar_s;
   typedef struct packed {
      logic [7:0] scsr;
      logic [1:0] cnt;
      logic [9:0] fifo0;
      logic [9:0] fifo1;
      logic [9:0] fifo2;
      logic holding_full;
      logic [7:0] holding_data;
      logic stuck;
   } ucs_state_s;
endpackage : ucs_pkg
`default_nettype wire

// File: ucs_peer.sv
// Far-side model: serializer and deserializer of the remote link.
// Assumes the block's plain one-clock handshakes.
`timescale 1ns/10ps
`default_nettype none
module ucs_peer
   import ucs_pkg::*;
(
   // Link side
   input wire logic clk,
   input wire logic tx_valid,
   output ucs_pkg::ucs_rxchar_s rx_char,
   output logic tx_take,
   output logic tx_stop_start
);
   import ucs_pkg::*;
   int age = 0;
   initial
   begin
      rx_char = '0;
      tx_take = 1'b0;
      tx_stop_start = 1'b0;
   end
   // ==========================================
   // Serializer: slow take, stop bit later
   always @(posedge clk)
   begin
      tx_take <= tx_valid && age == 2;
      tx_stop_start <= age == 5;
      age <= ((tx_valid || age > 2) && age < 5) ? age + 1 : 0;
   end
   // ==========================================
   // Deserializer: released fields show garbage
   task automatic send(input logic [7:0] d, input logic ok, input logic pb);
      @(posedge clk);
      rx_char <= '{1'b1, d, 1'b0, pb, ok};
      @(posedge clk);
      rx_char <= '{1'b0, ~d, 1'b1, ~pb, ~ok};
      #1;
   endtask : send
endmodule : ucs_peer
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the control/status register block.
// Assumes the far-side model answers over the tx and rx handshakes.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import ucs_pkg::*;
   logic clk = 0, rstn = 0, wr_s = 0, bit_wr = 0, buf_wr = 0, buf_rd = 0, par_en = 0, xbe = 0;
   logic [7:0] addr = 8'h98, wdata = 8'h00, rdata, bdata, tdata;
   logic [2:0] sel = 3'h0;
   logic tvalid, tstuck, ren, take, stop, textra;
   ucs_rxchar_s rxc;
   int n_errors = 0, checks = 0;
   logic [7:0] d [4] = '{8'ha1, 8'h52, 8'h3c, 8'he7};
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   ucs_ctrl_status uut (.REF_CLK(clk), .RSTN(rstn), .SFR_ADDR(addr), .SFR_WR(wr_s), .SFR_RD(1'b0),
      .SFR_BIT_WR(bit_wr), .SFR_BIT_SEL(sel), .SFR_WDATA(wdata), .BUF_WR(buf_wr), .BUF_RD(buf_rd),
      .SFR_RDATA(rdata), .BUF_RDATA(bdata), .PARITY_EN(par_en), .EXTRA_EN(xbe), .RX_CHAR(rxc),
      .RX_ENABLE(ren), .TX_VALID(tvalid), .TX_DATA(tdata), .TX_EXTRA(textra), .TX_TAKE(take),
      .TX_STOP_START(stop), .TX_STUCK_LOW(tstuck));
   ucs_peer peer (.clk(clk), .tx_valid(tvalid), .rx_char(rxc), .tx_take(take), .tx_stop_start(stop));
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Kind: 0 byte, 1 bit, 2 data buffer, 3 pop
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [2:0] s, input int k);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      sel <= s;
      {wr_s, bit_wr, buf_wr, buf_rd} <= 4'h8 >> k;
      @(posedge clk);
      {wr_s, bit_wr, buf_wr, buf_rd} <= 4'h0;
      #1;
   endtask : wr
   task automatic wait_bit(input int b);
      int i;
      for (i = 0; i < 20 && rdata[b] !== 1'b1; i++)
         @(posedge clk) #1;
      if (i == 20)
      begin
         n_errors++;
         conclude();
      end
   endtask : wait_bit
   task automatic conclude;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // ==========================================
   // Scenarios
   task automatic t_regs;
      chk(rdata, 8'h20);
      wr(8'h98, 8'hd8, 3'h0, 0);
      chk(rdata, 8'hf8);
      chk({7'h0, ren}, 8'h01);
      chk({7'h0, textra}, 8'h00);
      @(posedge clk);
      xbe <= 1'b1;
      @(posedge clk) #1;
      chk({7'h0, textra}, 8'h01);
      wr(8'h98, 8'h00, 3'h7, 1);
      chk(rdata, 8'h78);
      wr(8'h99, 8'hff, 3'h0, 0);
      chk(rdata, 8'h00);
      wr(8'h98, 8'h10, 3'h0, 0);
      chk(rdata, 8'h30);
      $display("regs done");
   endtask : t_regs
   task automatic t_rx;
      peer.send(d[0], 1'b1, 1'b0);
      peer.send(8'h77, 1'b0, 1'b0);
      peer.send(d[1], 1'b1, 1'b0);
      peer.send(d[2], 1'b1, 1'b0);
      chk(rdata, 8'h31);
      peer.send(d[3], 1'b1, 1'b0);
      chk(rdata, 8'hb1);
      chk(bdata, d[0]);
      wr(8'h98, 8'h01, 3'h0, 0);
      for (int i = 1; i < 3; i++)
      begin
         wr(8'h98, 8'h00, 3'h0, 3);
         chk(bdata, d[i]);
      end
      wr(8'h98, 8'h00, 3'h0, 3);
      wr(8'h98, 8'h00, 3'h0, 0);
      peer.send(d[3], 1'b1, 1'b0);
      chk(rdata, 8'h20);
      $display("rx done");
   endtask : t_rx
   task automatic t_par;
      @(posedge clk);
      par_en <= 1'b1;
      wr(8'h98, 8'h10, 3'h0, 0);
      peer.send(8'h5a, 1'b1, 1'b1);
      chk(rdata, 8'h71);
      wr(8'h98, 8'h00, 3'h0, 3);
      chk(rdata, 8'h71);
      wr(8'h98, 8'h00, 3'h0, 0);
      chk(rdata, 8'h20);
      @(posedge clk);
      par_en <= 1'b0;
      $display("parity done");
   endtask : t_par
   task automatic t_tx;
      wr(8'h98, 8'h96, 3'h0, 2);
      chk(rdata, 8'h00);
      chk(tdata, 8'h96);
      wait_bit(1);
      chk(rdata, 8'h22);
      wr(8'h98, 8'h11, 3'h0, 2);
      wr(8'h98, 8'h22, 3'h0, 2);
      chk({6'h0, tstuck, tvalid}, 8'h02);
      $display("tx done");
   endtask : t_tx
   // Wedged transmitter survives until a mid-run reset clears it
   task automatic t_rst;
      repeat (4) @(posedge clk);
      #1;
      chk({6'h0, tstuck, tvalid}, 8'h02);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk) #1;
      chk({6'h0, tstuck, tvalid}, 8'h00);
      chk(rdata, 8'h20);
      chk(bdata, 8'h00);
      wr(8'h98, 8'h5a, 3'h0, 2);
      chk({6'h0, tstuck, tvalid}, 8'h01);
      $display("reset done");
   endtask : t_rst
   initial
   begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk) #1;
      t_regs();
      t_rx();
      t_par();
      t_tx();
      t_rst();
      conclude();
   end
endmodule : testbench
`default_nettype wire
